/* File: lrre_pkg.sv */
// constants for the literal-return and rotate-left execution slice
package lrre_pkg;

  localparam int unsigned INSTR_W   = 12;
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned FILE_AW   = 5;
  localparam int unsigned PC_W_DEF  = 10;

  // opcode fields
  localparam int unsigned LIT_OP_HI = 11;
  localparam int unsigned LIT_OP_LO = 8;
  localparam int unsigned ROT_OP_HI = 11;
  localparam int unsigned ROT_OP_LO = 6;
  localparam int unsigned DEST_BIT  = 5;
  localparam int unsigned ADDR_HI   = 4;
  localparam int unsigned LIT_HI    = 7;
  localparam int unsigned MSB_BIT   = 7;

  localparam logic [3:0] OP_LIT_RET  = 4'h8;
  localparam logic [5:0] OP_ROT_LEFT = 6'h0D;

  // reset values
  localparam logic [DATA_W-1:0] W_RST     = 8'h00;
  localparam logic [DATA_W-1:0] RDATA_RST = 8'h00;
  localparam logic              CARRY_RST = 1'b0;

  typedef enum logic [0:0] {
    LRRE_RUN,
    LRRE_REFILL
  } lrre_state_e;

endpackage

/* File: lrre_mem_if.sv */
// register-file access bundle between executor and file memory
interface lrre_mem_if #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 8
);
  logic [AW-1:0] raddr;
  logic [DW-1:0] rdata;
  logic          we;
  logic [AW-1:0] waddr;
  logic [DW-1:0] wdata;

  modport ctrl (output raddr, output we, output waddr, output wdata, input rdata);
  modport mem  (input raddr, input we, input waddr, input wdata, output rdata);
endinterface

/* File: lrre_regfile.sv */
// file register memory with registered read data
module lrre_regfile #(
  parameter int unsigned AW = 5,
  parameter int unsigned DW = 8
) (
  // clock and reset
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  // access port
  lrre_mem_if.mem   mif
);
  import lrre_pkg::*;

  logic [DW-1:0] store_q [2**AW];
  logic [DW-1:0] rdata_d;
  logic [DW-1:0] rdata_q;

  // read returns the value before a same-cycle write
  always_comb
  begin
    rdata_d = store_q[mif.raddr];
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      rdata_q <= RDATA_RST;
    end
    else
    begin
      rdata_q <= rdata_d;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (mif.we)
    begin
      store_q[mif.waddr] <= mif.wdata;
    end
  end

  assign mif.rdata = rdata_q;

endmodule // lrre_regfile

/* File: lrre_exec.sv */
// execution slice for literal return and rotate left through carry
module lrre_exec #(
  parameter int unsigned PC_W = lrre_pkg::PC_W_DEF
) (
  // clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         rst_i,
  // instruction issue
  input  wire logic                         instr_valid_i,
  input  wire logic [lrre_pkg::INSTR_W-1:0] instr_i,
  output logic                              ready_o,
  // return stack
  input  wire logic [PC_W-1:0]              stack_top_i,
  // file register preload
  input  wire logic                         preload_we_i,
  input  wire logic [lrre_pkg::FILE_AW-1:0] preload_addr_i,
  input  wire logic [lrre_pkg::DATA_W-1:0]  preload_data_i,
  // core state
  output logic [lrre_pkg::DATA_W-1:0]       w_o,
  output logic                              carry_o,
  output logic [PC_W-1:0]                   pc_o,
  output logic                              pc_load_o,
  output logic                              done_o,
  // file register write mirror
  output logic                              file_we_o,
  output logic [lrre_pkg::FILE_AW-1:0]      file_addr_o,
  output logic [lrre_pkg::DATA_W-1:0]       file_data_o
);
  import lrre_pkg::*;

  lrre_mem_if #(.AW(FILE_AW), .DW(DATA_W)) mif ();

  lrre_regfile #(
    .AW (FILE_AW),
    .DW (DATA_W)
  ) u_regfile (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .mif       (mif)
  );

  lrre_state_e          state_q;
  lrre_state_e          state_d;
  logic                 ready_q;
  logic                 ready_d;
  logic [DATA_W-1:0]    w_q;
  logic [DATA_W-1:0]    w_d;
  logic                 carry_q;
  logic                 carry_d;
  logic [PC_W-1:0]      pc_q;
  logic [PC_W-1:0]      pc_d;
  logic                 pc_load_q;
  logic                 pc_load_d;
  logic                 done_q;
  logic                 done_d;
  logic                 fwe_q;
  logic                 fwe_d;
  logic [FILE_AW-1:0]   faddr_q;
  logic [FILE_AW-1:0]   faddr_d;
  logic [DATA_W-1:0]    fdata_q;
  logic [DATA_W-1:0]    fdata_d;
  logic                 ex_rot_q;
  logic                 ex_rot_d;
  logic                 ex_dest_q;
  logic                 ex_dest_d;
  logic [FILE_AW-1:0]   ex_addr_q;
  logic [FILE_AW-1:0]   ex_addr_d;
  logic                 ex_fwd_q;
  logic                 ex_fwd_d;
  logic [DATA_W-1:0]    ex_fwd_data_q;
  logic [DATA_W-1:0]    ex_fwd_data_d;

  logic                 issue;
  logic                 is_lit;
  logic                 is_rot;
  logic                 core_we;
  logic [DATA_W-1:0]    src;
  logic [DATA_W-1:0]    rot_res;

  // decode and file access
  always_comb
  begin
    issue     = instr_valid_i & ready_q;
    is_lit    = (instr_i[LIT_OP_HI:LIT_OP_LO] == OP_LIT_RET);
    is_rot    = (instr_i[ROT_OP_HI:ROT_OP_LO] == OP_ROT_LEFT);
    mif.raddr = instr_i[ADDR_HI:0];
    // a write in the same cycle as the read is forwarded, memory returns old data
    src       = ex_fwd_q ? ex_fwd_data_q : mif.rdata;
    rot_res   = {src[MSB_BIT-1:0], carry_q};
    core_we   = ex_rot_q & ex_dest_q;
    // core write wins; a colliding preload is dropped
    mif.we    = core_we | preload_we_i;
    mif.waddr = core_we ? ex_addr_q : preload_addr_i;
    mif.wdata = core_we ? rot_res : preload_data_i;
  end

  // next state
  always_comb
  begin
    state_d       = state_q;
    w_d           = w_q;
    carry_d       = carry_q;
    pc_d          = pc_q;
    pc_load_d     = 1'b0;
    ex_rot_d      = issue & is_rot;
    ex_dest_d     = instr_i[DEST_BIT];
    ex_addr_d     = instr_i[ADDR_HI:0];
    ex_fwd_d      = mif.we && (mif.waddr == instr_i[ADDR_HI:0]);
    ex_fwd_data_d = mif.wdata;
    fwe_d         = core_we;
    faddr_d       = ex_addr_q;
    fdata_d       = rot_res;
    done_d        = ex_rot_q | (state_q == LRRE_REFILL);
    if (ex_rot_q)
    begin
      carry_d = src[MSB_BIT];
      if (!ex_dest_q)
      begin
        w_d = rot_res;
      end
    end
    // a later literal return overrides an older rotate into W
    if (issue && is_lit)
    begin
      w_d       = instr_i[LIT_HI:0];
      pc_d      = stack_top_i;
      pc_load_d = 1'b1;
    end
    case (state_q)
      LRRE_RUN:
      begin
        if (issue && is_lit)
        begin
          state_d = LRRE_REFILL;
        end
      end
      LRRE_REFILL:
      begin
        state_d = LRRE_RUN;
      end
      default:
      begin
        state_d = LRRE_RUN;
      end
    endcase
    ready_d = (state_d == LRRE_RUN);
  end

  always_ff @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      state_q       <= LRRE_RUN;
      ready_q       <= 1'b1;
      w_q           <= W_RST;
      carry_q       <= CARRY_RST;
      pc_q          <= '0;
      pc_load_q     <= 1'b0;
      done_q        <= 1'b0;
      fwe_q         <= 1'b0;
      faddr_q       <= '0;
      fdata_q       <= '0;
      ex_rot_q      <= 1'b0;
      ex_dest_q     <= 1'b0;
      ex_addr_q     <= '0;
      ex_fwd_q      <= 1'b0;
      ex_fwd_data_q <= '0;
    end
    else
    begin
      state_q       <= state_d;
      ready_q       <= ready_d;
      w_q           <= w_d;
      carry_q       <= carry_d;
      pc_q          <= pc_d;
      pc_load_q     <= pc_load_d;
      done_q        <= done_d;
      fwe_q         <= fwe_d;
      faddr_q       <= faddr_d;
      fdata_q       <= fdata_d;
      ex_rot_q      <= ex_rot_d;
      ex_dest_q     <= ex_dest_d;
      ex_addr_q     <= ex_addr_d;
      ex_fwd_q      <= ex_fwd_d;
      ex_fwd_data_q <= ex_fwd_data_d;
    end
  end

  assign ready_o     = ready_q;
  assign w_o         = w_q;
  assign carry_o     = carry_q;
  assign pc_o        = pc_q;
  assign pc_load_o   = pc_load_q;
  assign done_o      = done_q;
  assign file_we_o   = fwe_q;
  assign file_addr_o = faddr_q;
  assign file_data_o = fdata_q;

  property p_pc_from_stack;
    @(posedge sys_clk_i) disable iff (rst_i)
    issue && is_lit |=> pc_load_o && (pc_o == $past(stack_top_i));
  endproperty
  a_pc_from_stack: assert property (p_pc_from_stack)
    else $error("pc not loaded from stack top");

  property p_lit_to_w;
    @(posedge sys_clk_i) disable iff (rst_i)
    issue && is_lit |=> (w_o == $past(instr_i[LIT_HI:0]))
      && (carry_o == ($past(ex_rot_q) ? $past(src[MSB_BIT]) : $past(carry_o)));
  endproperty
  a_lit_to_w: assert property (p_lit_to_w)
    else $error("literal not in W or carry changed");

  property p_two_cycles;
    @(posedge sys_clk_i) disable iff (rst_i)
    issue && is_lit |=> !ready_o ##1 (ready_o && done_o);
  endproperty
  a_two_cycles: assert property (p_two_cycles)
    else $error("literal return not two cycles");

  property p_rot_carry;
    @(posedge sys_clk_i) disable iff (rst_i)
    ex_rot_q |=> carry_o == $past(src[MSB_BIT]);
  endproperty
  a_rot_carry: assert property (p_rot_carry)
    else $error("carry not old bit seven");

  property p_carry_hold;
    @(posedge sys_clk_i) disable iff (rst_i)
    !ex_rot_q |=> $stable(carry_o);
  endproperty
  a_carry_hold: assert property (p_carry_hold)
    else $error("carry changed outside rotate");

  property p_rot_addr;
    @(posedge sys_clk_i) disable iff (rst_i)
    issue && is_rot && instr_i[DEST_BIT] |=> ##1 file_we_o && (file_addr_o == $past(instr_i[ADDR_HI:0], 2));
  endproperty
  a_rot_addr: assert property (p_rot_addr)
    else $error("rotate wrote wrong register");

  property p_rot_to_w;
    @(posedge sys_clk_i) disable iff (rst_i)
    ex_rot_q && !ex_dest_q && !(issue && is_lit) |=> !file_we_o && (w_o == $past(rot_res));
  endproperty
  a_rot_to_w: assert property (p_rot_to_w)
    else $error("rotate to W misrouted");

  property p_rot_single;
    @(posedge sys_clk_i) disable iff (rst_i)
    ex_rot_q && ex_dest_q |=> done_o && (file_data_o == {$past(src[MSB_BIT-1:0]), $past(carry_o)});
  endproperty
  a_rot_single: assert property (p_rot_single)
    else $error("rotate result wrong");

  c_lit: cover property (@(posedge sys_clk_i) disable iff (rst_i) issue && is_lit);
  c_rot_file: cover property (@(posedge sys_clk_i) disable iff (rst_i) ex_rot_q && ex_dest_q);
  c_rot_w: cover property (@(posedge sys_clk_i) disable iff (rst_i) ex_rot_q && !ex_dest_q);
  c_rot_fwd: cover property (@(posedge sys_clk_i) disable iff (rst_i) ex_rot_q && ex_fwd_q);

endmodule // lrre_exec

/* File: lrre_exec_tb.sv */
// self-checking bench for the literal return and rotate left execution slice
module lrre_exec_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import lrre_pkg::*;

  localparam int unsigned TB_PC_W = 10;
  localparam int          LIMIT   = 2000;

  logic                   sys_clk_i, rst_i, instr_valid_i, preload_we_i;
  logic                   ready_o, carry_o, pc_load_o, done_o, file_we_o;
  logic [INSTR_W-1:0]     instr_i;
  logic [TB_PC_W-1:0]     stack_top_i, pc_o;
  logic [FILE_AW-1:0]     preload_addr_i, file_addr_o;
  logic [DATA_W-1:0]      preload_data_i, w_o, file_data_o;

  // reference model state
  int          mem [32];
  int          mw, mc, mpc, rdy, r;
  int          pr_v, pr_d, pr_a, lit_prev;
  int          e_pl, e_done, e_we, e_fa, e_fd;
  int          fails, checks, cyc;
  logic        tk;
  logic [31:0] seed;
  logic [31:0] rnd;

  lrre_exec #(
    .PC_W (TB_PC_W)
  ) lrre_exec_inst (
    .sys_clk_i      (sys_clk_i),
    .rst_i          (rst_i),
    .instr_valid_i  (instr_valid_i),
    .instr_i        (instr_i),
    .ready_o        (ready_o),
    .stack_top_i    (stack_top_i),
    .preload_we_i   (preload_we_i),
    .preload_addr_i (preload_addr_i),
    .preload_data_i (preload_data_i),
    .w_o            (w_o),
    .carry_o        (carry_o),
    .pc_o           (pc_o),
    .pc_load_o      (pc_load_o),
    .done_o         (done_o),
    .file_we_o      (file_we_o),
    .file_addr_o    (file_addr_o),
    .file_data_o    (file_data_o)
  );

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    if (fails == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask

  initial
  begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end

  // hang guard
  always @(posedge sys_clk_i)
  begin
    cyc++;
    if (cyc == LIMIT)
    begin
      fails++;
      test_done();
    end
  end

  initial
  begin
    seed = 32'd73481;
    rst_i = 1'b1;
    instr_valid_i = 1'b0;
    instr_i = 12'h000;
    stack_top_i = '0;
    preload_we_i = 1'b0;
    preload_addr_i = 5'h00;
    preload_data_i = 8'h00;
    rdy = 1;
    repeat (5) @(posedge sys_clk_i);
    chk(ready_o, 1);
    chk(w_o, 0);
    chk(carry_o, 0);
    chk(pc_o, 0);
    rst_i <= 1'b0;
    // fill every file register with random contents
    for (int a = 0; a < 32; a++)
    begin
      @(posedge sys_clk_i);
      rnd = xs();
      preload_we_i <= 1'b1;
      preload_addr_i <= a[4:0];
      preload_data_i <= rnd[7:0];
      mem[a] = rnd[7:0];
    end
    @(posedge sys_clk_i);
    preload_we_i <= 1'b0;
    // random back-to-back stream, some offered while not ready
    for (int n = 0; n < 600; n++)
    begin
      @(posedge sys_clk_i);
      e_pl = 0;
      e_we = 0;
      e_done = lit_prev;
      if (pr_v != 0)
      begin
        r = ((mem[pr_a] << 1) | mc) & 255;
        mc = (mem[pr_a] >> 7) & 1;
        if (pr_d != 0)
        begin
          mem[pr_a] = r;
          e_we = 1;
          e_fa = pr_a;
          e_fd = r;
        end
        else
          mw = r;
        e_done = 1;
      end
      pr_v = 0;
      lit_prev = 0;
      tk = instr_valid_i && (rdy != 0);
      if (tk && instr_i[11:8] == OP_LIT_RET)
      begin
        mw = instr_i[7:0];
        mpc = stack_top_i;
        e_pl = 1;
        lit_prev = 1;
      end
      else if (tk && instr_i[11:6] == OP_ROT_LEFT)
      begin
        pr_v = 1;
        pr_d = instr_i[5];
        pr_a = instr_i[4:0];
      end
      rdy = (e_pl != 0) ? 0 : 1;
      rnd = xs();
      instr_valid_i <= rnd[0] | rnd[1];
      stack_top_i <= rnd[25:16];
      if (rnd[4:2] < 3)
        instr_i <= {4'h8, rnd[15:8]};
      else if (rnd[4:2] < 7)
        instr_i <= {6'h0D, rnd[13:8]};
      else
        instr_i <= {4'h0, rnd[15:8]};
      @(negedge sys_clk_i);
      chk(ready_o, rdy);
      chk(pc_load_o, e_pl);
      chk(pc_o, mpc);
      chk(w_o, mw);
      chk(carry_o, mc);
      chk(done_o, e_done);
      chk(file_we_o, e_we);
      if (e_we != 0)
      begin
        chk(file_addr_o, e_fa);
        chk(file_data_o, e_fd);
      end
    end
    test_done();
  end

endmodule // lrre_exec_tb
